// File: rtl/rcd_defs.svh
// Constants for the reset cause detector: offsets, flag positions, masks, counts
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH

// Bus decode
`define RCD_ADR_W 8
`define RCD_OFS_FLAGS 8'h00

// Flag bit positions in the reset cause register
`define RCD_BIT_TRAP 15
`define RCD_BIT_ILL 14
`define RCD_BIT_CM 9
`define RCD_BIT_EXT 7
`define RCD_BIT_SWR 6
`define RCD_BIT_WDT 4
`define RCD_BIT_SLEEP 3
`define RCD_BIT_IDLE 2
`define RCD_BIT_BOR 1
`define RCD_BIT_POR 0

// Implemented flags, flags cleared by brown-out, value after power-on
`define RCD_IMPL_MASK 16'hC2DF
`define RCD_BOR_CLR_MASK 16'hC25C
`define RCD_FLAGS_POR 16'h0003

// Working register valid vector after reset: only the stack pointer stays valid
`define RCD_WREG_RST 16'h8000

// Illegal opcode in the upper byte, hard trap level range
`define RCD_ILL_OPC 8'h3F
`define RCD_HARD_MIN 4'hD
`define RCD_HARD_MAX 4'hF

// Length of a generated system reset in clock cycles
`define RCD_SYSRST_CYCLES 3'h4

`endif

// File: rtl/rcd_pkg.sv
// Types shared by the reset cause detector
package rcd_pkg;
	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_HOLD = 1'b1
	} rcd_state_e;
	typedef logic [15:0] rcd_flags_t;
endpackage

// File: rtl/rcd_reset_cause.sv
// Reset cause detector with the reset cause register on a Wishbone slave
// Function
// - Lower-priority hard trap during higher-priority trap handling causes a conflict reset.
// - Priority levels 13 to 15 are hard traps.
// - Trap-conflict reset sets bit 15 of the reset cause register.
// - Pin-select control and its shadow are compared every cycle while the core runs; difference causes reset.
// - Mismatch reset sets bit 9; feature may be left out by parameter.
// - Illegal opcode, uninitialised pointer or security reset sets bit 14.
// - Executing a fetched illegal opcode resets the device.
// - Upper byte 0x3F in an instruction word is an illegal opcode.
// - Using an unwritten working register as pointer resets the device.
// - Every reset marks all working registers but 15 unwritten.
// - Flow change into a restricted protected location causes a security reset.
// - Calls, jumps, returns and branches reloading the PC are program flow changes.
// - PC reload with an interrupt or trap vector is a vector flow change.
// - Power-on and brown-out clear most flags; external flag only by power-on.
// - Watchdog flag bit 4 cleared by power-save, watchdog clear, power-on, brown-out.
// - Power-save sets sleep bit 3 or idle bit 2 by selected mode.
// - Software writes may set or clear every flag bit.
// - Power-on reset sets bit 0.
// - Brown-out sets bit 1; power-on sets it too.
// - Reset instruction sets software-reset bit 6.
// - Watchdog time-out reset sets bit 4.
`timescale 1ns/1ps
`include "rcd_defs.svh"

module rcd_reset_cause #(
	parameter int PPS_W = 16,
	parameter bit CM_EN = 1'b1,
	parameter logic [23:0] SEC_LO = 24'h000200,
	parameter logic [23:0] SEC_HI = 24'h0003FF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic [`RCD_ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	// Trap logic
	input wire logic trap_busy_i,
	input wire logic [3:0] trap_busy_lvl_i,
	input wire logic trap_req_i,
	input wire logic [3:0] trap_req_lvl_i,
	// Pin-select configuration and its hardware shadow
	input wire logic [PPS_W-1:0] pps_ctrl_i,
	input wire logic [PPS_W-1:0] pps_shadow_i,
	// Fetch and execute
	input wire logic instr_exec_i,
	input wire logic [23:0] instr_word_i,
	input wire logic wreg_wr_i,
	input wire logic [3:0] wreg_wr_idx_i,
	input wire logic ptr_use_i,
	input wire logic [3:0] ptr_idx_i,
	input wire logic pc_load_i,
	input wire logic pc_load_vec_i,
	input wire logic [23:0] pc_target_i,
	input wire logic sec_protect_i,
	// Special instructions and other causes
	input wire logic reset_instr_i,
	input wire logic power_save_i,
	input wire logic power_save_idle_i,
	input wire logic watchdog_clear_i,
	input wire logic wdt_timeout_i,
	input wire logic brownout_i,
	input wire logic master_clear_n_i,
	// Results
	output logic sys_rst_o,
	output logic [15:0] wreg_valid_o
);

	// Hard traps are the top three priority levels
	function automatic logic is_hard(input logic [3:0] lvl);
		is_hard = (lvl >= `RCD_HARD_MIN) && (lvl <= `RCD_HARD_MAX);
	endfunction

	function automatic logic is_restricted(input logic [23:0] a);
		is_restricted = (a >= SEC_LO) && (a <= SEC_HI);
	endfunction

	rcd_pkg::rcd_state_e st_r;
	rcd_pkg::rcd_state_e st_nxt;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	rcd_pkg::rcd_flags_t flags_r;
	rcd_pkg::rcd_flags_t flags_nxt;
	rcd_pkg::rcd_flags_t set_vec;
	logic [15:0] wreg_r;
	logic [15:0] wreg_nxt;
	logic master_clear_pin_s1_r;
	logic master_clear_pin_s2_r;
	logic master_clear_pin_s3_r;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic run;
	logic trap_conflict;
	logic cfg_mismatch;
	logic ill_opcode;
	logic uninit_ptr;
	logic sec_fault;
	logic master_clear_pin_fall;
	logic cause_any;
	logic bus_req;
	logic hit_flags;
	logic wr_commit;
	logic program_flow_change;
	logic vector_flow_change;

	// Core-side causes only count while the core runs; in reset its strobes are junk
	assign run = (st_r == rcd_pkg::ST_RUN);

	// Only a hard request below the level in service is a conflict
	assign trap_conflict = run && trap_busy_i && trap_req_i && is_hard(trap_req_lvl_i)
		&& is_hard(trap_busy_lvl_i) && (trap_req_lvl_i < trap_busy_lvl_i);

	// Compared every cycle while the core runs, so a disturbed cell is caught at once
	assign cfg_mismatch = CM_EN && run && (pps_ctrl_i != pps_shadow_i);

	assign ill_opcode = run && instr_exec_i && (instr_word_i[23:16] == `RCD_ILL_OPC);

	assign uninit_ptr = run && ptr_use_i && !wreg_r[ptr_idx_i];

	// Program and vector flow changes both arrive as a PC reload and are policed alike
	assign program_flow_change = pc_load_i && !pc_load_vec_i;
	assign vector_flow_change = pc_load_i && pc_load_vec_i;
	assign sec_fault = run && (program_flow_change || vector_flow_change) && sec_protect_i
		&& is_restricted(pc_target_i);

	// External pin reset seen as a falling edge after synchronising
	assign master_clear_pin_fall = master_clear_pin_s3_r && !master_clear_pin_s2_r;

	// Any cause starts a system reset
	assign cause_any = trap_conflict || cfg_mismatch || ill_opcode || uninit_ptr
		|| sec_fault || (run && reset_instr_i) || wdt_timeout_i || brownout_i
		|| master_clear_pin_fall;

	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			master_clear_pin_s1_r <= 1'b1;
			master_clear_pin_s2_r <= 1'b1;
			master_clear_pin_s3_r <= 1'b1;
		end else begin
			master_clear_pin_s1_r <= master_clear_n_i;
			master_clear_pin_s2_r <= master_clear_pin_s1_r;
			master_clear_pin_s3_r <= master_clear_pin_s2_r;
		end
	end

	// Reset sequencer: hold a fixed time, longer while the pin stays low
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			rcd_pkg::ST_RUN: begin
				if (cause_any) begin
					st_nxt = rcd_pkg::ST_HOLD;
					cnt_nxt = `RCD_SYSRST_CYCLES - 3'h1;
				end
			end
			rcd_pkg::ST_HOLD: begin
				if (wdt_timeout_i || brownout_i || master_clear_pin_fall) begin
					cnt_nxt = `RCD_SYSRST_CYCLES - 3'h1;
				end else if (cnt_r != 3'h0) begin
					cnt_nxt = cnt_r - 3'h1;
				end else if (master_clear_pin_s2_r) begin
					st_nxt = rcd_pkg::ST_RUN;
				end
			end
			default: begin
				st_nxt = rcd_pkg::ST_HOLD;
				cnt_nxt = `RCD_SYSRST_CYCLES - 3'h1;
			end
		endcase
	end

	// Power-on leaves the core held for the full reset time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= rcd_pkg::ST_HOLD;
			cnt_r <= `RCD_SYSRST_CYCLES - 3'h1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign sys_rst_o = (st_r == rcd_pkg::ST_HOLD);

	// Working register written marks; writes during reset are ignored
	always_comb begin
		wreg_nxt = wreg_r;
		if (!run) begin
			wreg_nxt = `RCD_WREG_RST;
		end else if (wreg_wr_i) begin
			wreg_nxt[wreg_wr_idx_i] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wreg_r <= `RCD_WREG_RST;
		end else begin
			wreg_r <= wreg_nxt;
		end
	end

	assign wreg_valid_o = wreg_r;

	// Hardware set events for each flag but the power-on flag, bit 0, which only rst_i and software writes load
	always_comb begin
		set_vec = '0;
		set_vec[`RCD_BIT_TRAP] = trap_conflict;
		set_vec[`RCD_BIT_ILL] = ill_opcode || uninit_ptr || sec_fault;
		set_vec[`RCD_BIT_CM] = cfg_mismatch;
		set_vec[`RCD_BIT_EXT] = master_clear_pin_fall;
		set_vec[`RCD_BIT_SWR] = run && reset_instr_i;
		set_vec[`RCD_BIT_WDT] = wdt_timeout_i;
		set_vec[`RCD_BIT_SLEEP] = run && power_save_i && !power_save_idle_i;
		set_vec[`RCD_BIT_IDLE] = run && power_save_i && power_save_idle_i;
		set_vec[`RCD_BIT_BOR] = brownout_i;
	end

	// Bus handshake: one request answered one cycle after it is seen
	assign bus_req = cyc_i && stb_i && !ack_r;
	assign hit_flags = (adr_i == `RCD_OFS_FLAGS);
	// Write lands at the edge where the master samples ack, so a held request writes once
	assign wr_commit = cyc_i && stb_i && we_i && ack_r && hit_flags;

	// Flag update: software write, then clears, then hardware sets win over both
	always_comb begin
		flags_nxt = flags_r;
		if (wr_commit) begin
			if (sel_i[0]) begin
				flags_nxt[7:0] = dat_i[7:0];
			end
			if (sel_i[1]) begin
				flags_nxt[15:8] = dat_i[15:8];
			end
		end
		if (brownout_i) begin
			flags_nxt = flags_nxt & ~`RCD_BOR_CLR_MASK;
		end
		if (run && (power_save_i || watchdog_clear_i)) begin
			flags_nxt[`RCD_BIT_WDT] = 1'b0;
		end
		flags_nxt = (flags_nxt | set_vec) & `RCD_IMPL_MASK;
	end

	// Power-on clears everything, external flag included, and sets both power flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= `RCD_FLAGS_POR;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Read data and ack; unmapped addresses answer with zero and drop writes
	always_comb begin
		ack_nxt = bus_req;
		dat_nxt = dat_r;
		if (bus_req) begin
			dat_nxt = hit_flags ? {16'h0000, flags_r} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_trap_flag: assert property (trap_conflict |=> flags_r[15] && sys_rst_o)
		else $error("Trap conflict did not set flag and reset");
	chk_hard_only: assert property (trap_req_i && trap_busy_i && run
		&& trap_req_lvl_i < 4'hD |=> !flags_r[15] || $past(flags_r[15]) || $past(we_i))
		else $error("Soft trap raised a conflict");
	chk_cm_flag: assert property (run && pps_ctrl_i != pps_shadow_i
		|=> (flags_r[9] == CM_EN) && (sys_rst_o || !CM_EN))
		else $error("Mismatch not handled");
	chk_ill_opc: assert property (run && instr_exec_i && instr_word_i[23:16] == 8'h3F
		|=> flags_r[14] && sys_rst_o)
		else $error("Illegal opcode not reset");
	chk_uninit_ptr: assert property (run && ptr_use_i && !wreg_valid_o[ptr_idx_i]
		|=> flags_r[14] && sys_rst_o)
		else $error("Uninitialised pointer not reset");
	chk_wreg_clear: assert property (sys_rst_o |=> wreg_valid_o == 16'h8000)
		else $error("Working registers not marked unwritten");
	chk_sec_fault: assert property (run && pc_load_i && sec_protect_i
		&& pc_target_i >= SEC_LO && pc_target_i <= SEC_HI |=> flags_r[14] && sys_rst_o)
		else $error("Security reset missed");
	chk_bor_clear: assert property (brownout_i && !reset_instr_i |=>
		flags_r[1] && !flags_r[6] && !flags_r[3] && !flags_r[2] && !flags_r[15])
		else $error("Brown-out flag update wrong");
	chk_ext_keep: assert property (brownout_i && flags_r[7] |=> flags_r[7])
		else $error("Brown-out cleared external flag");
	chk_wdt_clear: assert property (run && (power_save_i || watchdog_clear_i)
		&& !wdt_timeout_i |=> !flags_r[4])
		else $error("Watchdog flag not cleared");
	chk_rst_len: assert property ($rose(sys_rst_o) |-> sys_rst_o[*4])
		else $error("System reset too short");
	chk_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("Bus ack timing wrong");

endmodule // rcd_reset_cause

// File: tb/rcd_core_model.sv
// Core-side model: fetch, pointer, flow change and trap events on command
`timescale 1ns/1ps

module rcd_core_model (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] cmd_i,
	input wire logic go_i,
	output logic trap_busy_o = 1'b0,
	output logic [3:0] trap_busy_lvl_o = 4'h0,
	output logic trap_req_o = 1'b0,
	output logic [3:0] trap_req_lvl_o = 4'h0,
	output logic instr_exec_o = 1'b0,
	output logic [23:0] instr_word_o = 24'h000000,
	output logic wreg_wr_o = 1'b0,
	output logic [3:0] wreg_wr_idx_o = 4'h3,
	output logic ptr_use_o = 1'b0,
	output logic [3:0] ptr_idx_o = 4'h3,
	output logic pc_load_o = 1'b0,
	output logic pc_load_vec_o = 1'b0,
	output logic [23:0] pc_target_o = 24'h000000,
	output logic sec_protect_o = 1'b1
);
	logic pend_r = 1'b0;

	// One-cycle events; a core held in reset issues nothing
	always_ff @(posedge clk_i) begin
		{instr_exec_o, wreg_wr_o, pc_load_o, trap_req_o, trap_busy_o} <= 5'h00;
		ptr_use_o <= pend_r;
		pend_r <= 1'b0;
		if (go_i && !sys_rst_i) begin
			case (cmd_i)
			4'h0: begin
				instr_exec_o <= 1'b1;
				instr_word_o <= 24'h3F1234;
			end
			4'hC: begin
				instr_exec_o <= 1'b1;
				instr_word_o <= 24'h3E1234;
			end
			4'h1: ptr_use_o <= 1'b1;
			// Write first, use as pointer on the next cycle
			4'hD: begin
				wreg_wr_o <= 1'b1;
				pend_r <= 1'b1;
			end
			4'h2: begin
				pc_load_o <= 1'b1;
				pc_load_vec_o <= 1'b0;
				pc_target_o <= 24'h000200;
			end
			4'h3: begin
				pc_load_o <= 1'b1;
				pc_load_vec_o <= 1'b1;
				pc_target_o <= 24'h0003FF;
			end
			4'hF: begin
				pc_load_o <= 1'b1;
				pc_target_o <= 24'h000400;
			end
			4'h4: begin
				{trap_busy_o, trap_req_o} <= 2'h3;
				trap_busy_lvl_o <= 4'hE;
				trap_req_lvl_o <= 4'hD;
			end
			4'hE: begin
				{trap_busy_o, trap_req_o} <= 2'h3;
				trap_busy_lvl_o <= 4'hD;
				trap_req_lvl_o <= 4'hE;
			end
			// Soft request under a hard trap in service is no conflict
			4'h5: begin
				{trap_busy_o, trap_req_o} <= 2'h3;
				trap_busy_lvl_o <= 4'hE;
				trap_req_lvl_o <= 4'h7;
			end
			default: ;
			endcase
		end
	end
endmodule // rcd_core_model

// File: tb/rcd_reset_cause_bench.sv
// Bench for the reset cause detector: bus tasks and a table of causes
`timescale 1ns/1ps
`include "rcd_defs.svh"

module rcd_reset_cause_bench;
	logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, go = 1'b0;
	logic reset_instr_i = 1'b0, power_save_i = 1'b0, power_save_idle_i = 1'b0;
	logic watchdog_clear_i = 1'b0, wdt_timeout_i = 1'b0, brownout_i = 1'b0, master_clear_n_i = 1'b1;
	logic [`RCD_ADR_W-1:0] adr_i = '0;
	logic [31:0] dat_i = '0;
	logic [3:0] sel_i = 4'h3, cmd = 4'h0;
	logic [15:0] pps_ctrl_i = 16'h0000, pps_shadow_i = 16'h0000;
	logic [31:0] dat_o;
	logic ack_o, sys_rst_o, trap_busy_i, trap_req_i, instr_exec_i, wreg_wr_i, ptr_use_i;
	logic pc_load_i, pc_load_vec_i, sec_protect_i;
	logic [3:0] trap_busy_lvl_i, trap_req_lvl_i, wreg_wr_idx_i, ptr_idx_i;
	logic [23:0] instr_word_i, pc_target_i;
	logic [15:0] wreg_valid_o, q;
	logic [15:0] ef [0:15];
	int fails = 0, compares = 0, lat;

	rcd_reset_cause rcd_reset_cause_inst (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
		.cyc_i, .stb_i, .ack_o, .trap_busy_i, .trap_busy_lvl_i, .trap_req_i, .trap_req_lvl_i,
		.pps_ctrl_i, .pps_shadow_i, .instr_exec_i, .instr_word_i, .wreg_wr_i, .wreg_wr_idx_i,
		.ptr_use_i, .ptr_idx_i, .pc_load_i, .pc_load_vec_i, .pc_target_i, .sec_protect_i,
		.reset_instr_i, .power_save_i, .power_save_idle_i, .watchdog_clear_i, .wdt_timeout_i,
		.brownout_i, .master_clear_n_i, .sys_rst_o, .wreg_valid_o);
	rcd_core_model rcd_core_model_inst (.clk_i, .sys_rst_i(sys_rst_o), .cmd_i(cmd), .go_i(go),
		.trap_busy_o(trap_busy_i), .trap_busy_lvl_o(trap_busy_lvl_i), .trap_req_o(trap_req_i),
		.trap_req_lvl_o(trap_req_lvl_i), .instr_exec_o(instr_exec_i), .instr_word_o(instr_word_i),
		.wreg_wr_o(wreg_wr_i), .wreg_wr_idx_o(wreg_wr_idx_i), .ptr_use_o(ptr_use_i),
		.ptr_idx_o(ptr_idx_i), .pc_load_o(pc_load_i), .pc_load_vec_o(pc_load_vec_i),
		.pc_target_o(pc_target_i), .sec_protect_o(sec_protect_i));

	// 50 MHz clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Request held until ack is sampled, so no write lands twice
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s = 4'h3);
		int n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i} <= 2'h3;
		we_i <= w;
		sel_i <= s;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o[15:0];
		{cyc_i, stb_i} <= 2'h0;
		if (n >= 50) chk("ack_o", 16'h0001, 16'h0000);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0000);
		chk("flags", e, q);
	endtask

	// One-cycle cause, then the cycle count until system reset shows
	task automatic fire(input int c);
		@(posedge clk_i);
		case (c)
		5: reset_instr_i <= 1'b1;
		6: wdt_timeout_i <= 1'b1;
		7: pps_shadow_i <= 16'h0100;
		8: brownout_i <= 1'b1;
		9: master_clear_n_i <= 1'b0;
		10: power_save_i <= 1'b1;
		11: {power_save_i, power_save_idle_i} <= 2'h3;
		16: watchdog_clear_i <= 1'b1;
		default: {cmd, go} <= {c[3:0], 1'b1};
		endcase
		@(posedge clk_i);
		{reset_instr_i, wdt_timeout_i, brownout_i, power_save_i, watchdog_clear_i, go} <= 6'h00;
		{power_save_idle_i, master_clear_n_i} <= 2'h1;
		pps_shadow_i <= 16'h0000;
		lat = 0;
		for (int n = 1; n <= 6; n++) begin
			@(negedge clk_i);
			if (lat == 0 && sys_rst_o === 1'b1) lat = n;
		end
	endtask

	task automatic wait_run();
		int n = 0;
		while (sys_rst_o !== 1'b0 && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		chk("sys_rst_o", 16'h0000, {15'h0000, sys_rst_o});
	endtask

	task automatic finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence: reset values, access, cause table, clearing rules
	initial begin
		ef = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h8000, 16'h0040, 16'h0010, 16'h0200,
			16'h0002, 16'h0080, 16'h0008, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`RCD_OFS_FLAGS, `RCD_FLAGS_POR);
		chk("wreg_valid", 16'h8000, wreg_valid_o);
		wait_run();
		wb(1'b1, `RCD_OFS_FLAGS, 16'hFFFF);
		rd(`RCD_OFS_FLAGS, `RCD_IMPL_MASK);
		wb(1'b1, 8'h04, 16'h0000);
		rd(8'h04, 16'h0000);
		rd(`RCD_OFS_FLAGS, `RCD_IMPL_MASK);
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, `RCD_OFS_FLAGS, 16'h0000);
			fire(i);
			chk("sys_rst_o", 16'(i < 10), 16'(lat != 0));
			if (i < 9 && lat != 0) chk("latency", (i >= 5) ? 16'h1 : 16'h2, lat[15:0]);
			wait_run();
			rd(`RCD_OFS_FLAGS, ef[i]);
		end
		fire(21);
		chk("sys_rst_o", 16'h0000, 16'(lat != 0));
		rd(`RCD_OFS_FLAGS, 16'h0000);
		wb(1'b1, `RCD_OFS_FLAGS, 16'hFFFF, 4'h1);
		rd(`RCD_OFS_FLAGS, 16'h00DF);
		chk("wreg_valid", 16'h8008, wreg_valid_o);
		wb(1'b1, `RCD_OFS_FLAGS, 16'h0010);
		fire(16);
		rd(`RCD_OFS_FLAGS, 16'h0000);
		wb(1'b1, `RCD_OFS_FLAGS, 16'h0010);
		fire(10);
		rd(`RCD_OFS_FLAGS, 16'h0008);
		wb(1'b1, `RCD_OFS_FLAGS, 16'hFFFF);
		fire(8);
		wait_run();
		rd(`RCD_OFS_FLAGS, (`RCD_IMPL_MASK & ~`RCD_BOR_CLR_MASK) | 16'h0002);
		wb(1'b1, `RCD_OFS_FLAGS, 16'hFFFF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(`RCD_OFS_FLAGS, `RCD_FLAGS_POR);
		chk("wreg_valid", 16'h8000, wreg_valid_o);
		finish_test();
	end

	// A hang is cut short well after the expected run length
	initial begin
		#200000;
		chk("timeout", 16'h0000, 16'h0001);
		finish_test();
	end
endmodule // rcd_reset_cause_bench
